// >>> pll_status_defs.svh
`ifndef PLL_STATUS_DEFS_SVH
`define PLL_STATUS_DEFS_SVH

// Register addresses on the serial control port
`define ADDR_W               10
`define ZERO_DELAY_CFG_ADDR  10'h01E
`define PLL_STATUS_ADDR      10'h01F

// Zero-delay configuration fields
`define ZD_ENABLE_BIT        1
`define ZD_EXTERNAL_BIT      2
`define ZD_CFG_RESET         8'h00
`define ZD_CFG_MASK          8'h06

// Status fields
`define ST_LOCK_BIT          0
`define ST_FIRST_REFERENCE_INPUT_ABOVE_BIT    1
`define ST_SECOND_REFERENCE_INPUT_ABOVE_BIT    2
`define ST_VCO_ABOVE_BIT     3
`define ST_SECOND_REFERENCE_INPUT_SEL_BIT      4
`define ST_HOLDOVER_BIT      5
`define ST_CAL_DONE_BIT      6
`define ST_UNUSED_BIT        7

// Read data reset value
`define RD_DATA_RESET        8'h00
`define RD_DATA_MASK         8'hFF

`endif

// >>> pll_status_pkg.sv
`default_nettype none

package pll_status_pkg;

   typedef logic [9:0] reg_addr_t;
   typedef logic [7:0] reg_byte_t;

   typedef struct packed {
      reg_addr_t addr;
      logic      wr;
      logic      rd;
      reg_byte_t wdata;
   } reg_req_s;

   typedef struct packed {
      logic cal_done;
      logic holdover_active;
      logic second_ref_selected;
      logic vco_above_threshold;
      logic second_ref_above_threshold;
      logic first_ref_above_threshold;
      logic digital_lock;
   } pll_status_s;

   typedef enum logic [1:0] {
      ZD_OFF      = 2'h0,
      ZD_INTERNAL = 2'h1,
      ZD_EXTERNAL = 2'h3
   } zd_mode_e;

endpackage

`default_nettype wire

// >>> byte_reg.sv
`default_nettype none

module byte_reg #(
   parameter logic [7:0] RESET_VALUE = 8'h00,
   parameter logic [7:0] KEEP_MASK   = 8'hFF
) (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       srst,
   // Load port
   input  wire logic       load,
   input  wire logic [7:0] d,
   // Stored value
   output logic      [7:0] q
);

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         q <= RESET_VALUE & KEEP_MASK;
      end
      else if (load)
      begin
         q <= d & KEEP_MASK;
      end
   end

endmodule // byte_reg

`default_nettype wire

// >>> pll_status_readback.sv
// Functional notes
// - Zero-delay enable bit, cleared at reset
// - Mode bit: clear internal, set external
// - Status bit 6 shows calibration finished
// - Status bit 5 shows holdover actually active
// - Status bit 4 set: second reference selected
// - Status bit 3: VCO above threshold
// - Status bit 2: second reference above threshold
// - Status bit 1: first reference above threshold
// - Status bit 0 shows digital lock detect
`include "pll_status_defs.svh"
`default_nettype none

module pll_status_readback
   import pll_status_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        srst,
   // Register access from the serial control port
   input  wire reg_req_s    reg_req,
   output logic      [7:0]  rd_data,
   output logic             rd_valid,
   output logic             addr_error,
   // Live status from PLL, monitors, holdover and calibration
   input  wire pll_status_s pll_status,
   // Zero-delay control
   output logic             zero_delay_enable,
   output logic             external_zero_delay,
   output zd_mode_e         zero_delay_mode,
   // Status change event
   output logic             status_changed
);

   logic      hit_cfg;
   logic      hit_status;
   logic      cfg_write;
   logic      rd_load;
   reg_byte_t cfg_q;
   reg_byte_t status_word;
   reg_byte_t next_rd_data;
   reg_byte_t rd_q;
   reg_byte_t status_prev;
   logic      status_prev_ok;

   // Address decode
   always_comb
   begin
      hit_cfg    = (reg_req.addr == `ZERO_DELAY_CFG_ADDR);
      hit_status = (reg_req.addr == `PLL_STATUS_ADDR);
   end

   // Only the configuration register accepts writes
   always_comb
   begin
      cfg_write = reg_req.wr & hit_cfg;
   end

   // Zero-delay configuration storage
   byte_reg #(
      .RESET_VALUE (`ZD_CFG_RESET),
      .KEEP_MASK   (`ZD_CFG_MASK)
   ) u_zd_cfg (
      .core_clk (core_clk),
      .srst     (srst),
      .load     (cfg_write),
      .d        (reg_req.wdata),
      .q        (cfg_q)
   );

   // Zero-delay control outputs
   always_comb
   begin
      zero_delay_enable   = cfg_q[`ZD_ENABLE_BIT];
      external_zero_delay = cfg_q[`ZD_ENABLE_BIT] & cfg_q[`ZD_EXTERNAL_BIT];
   end

   // Decoded zero-delay mode
   always_comb
   begin
      case ({cfg_q[`ZD_ENABLE_BIT], cfg_q[`ZD_EXTERNAL_BIT]})
         2'h2:    zero_delay_mode = ZD_INTERNAL;
         2'h3:    zero_delay_mode = ZD_EXTERNAL;
         default: zero_delay_mode = ZD_OFF;
      endcase
   end

   // Status word assembly
   always_comb
   begin
      status_word                     = 8'h00;
      status_word[`ST_UNUSED_BIT]     = 1'b0;
      status_word[`ST_CAL_DONE_BIT]   = pll_status.cal_done;
      status_word[`ST_HOLDOVER_BIT]   = pll_status.holdover_active;
      status_word[`ST_SECOND_REFERENCE_INPUT_SEL_BIT]   = pll_status.second_ref_selected;
      status_word[`ST_VCO_ABOVE_BIT]  = pll_status.vco_above_threshold;
      status_word[`ST_SECOND_REFERENCE_INPUT_ABOVE_BIT] = pll_status.second_ref_above_threshold;
      status_word[`ST_FIRST_REFERENCE_INPUT_ABOVE_BIT] = pll_status.first_ref_above_threshold;
      status_word[`ST_LOCK_BIT]       = pll_status.digital_lock;
   end

   // Read data selection
   always_comb
   begin
      next_rd_data = 8'h00;
      if (hit_cfg)
      begin
         next_rd_data = cfg_q;
      end
      else if (hit_status)
      begin
         next_rd_data = status_word;
      end
   end

   always_comb
   begin
      rd_load = reg_req.rd;
   end

   // Read data holding register
   byte_reg #(
      .RESET_VALUE (`RD_DATA_RESET),
      .KEEP_MASK   (`RD_DATA_MASK)
   ) u_rd_data (
      .core_clk (core_clk),
      .srst     (srst),
      .load     (rd_load),
      .d        (next_rd_data),
      .q        (rd_q)
   );

   always_comb
   begin
      rd_data = rd_q;
   end

   // Read valid pulse
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         rd_valid <= 1'b0;
      end
      else
      begin
         rd_valid <= reg_req.rd;
      end
   end

   // Unmapped access or write to the read-only word
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         addr_error <= 1'b0;
      end
      else
      begin
         addr_error <= ((reg_req.rd | reg_req.wr) & ~hit_cfg & ~hit_status)
                       | (reg_req.wr & hit_status);
      end
   end

   // Status change detection
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         status_prev    <= 8'h00;
         status_prev_ok <= 1'b0;
      end
      else
      begin
         status_prev    <= status_word;
         status_prev_ok <= 1'b1;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         status_changed <= 1'b0;
      end
      else
      begin
         status_changed <= status_prev_ok & (status_prev != status_word);
      end
   end

endmodule // pll_status_readback

`default_nettype wire

// >>> pll_status_asserts.sv
`default_nettype none
module pll_status_asserts
   import pll_status_pkg::*;
(
   // Clock, reset
   input wire logic        core_clk,
   input wire logic        srst,
   // Register access
   input wire reg_req_s    reg_req,
   input wire logic [7:0]  rd_data,
   input wire logic        rd_valid,
   input wire logic        addr_error,
   // Status and control
   input wire pll_status_s pll_status,
   input wire logic        zero_delay_enable,
   input wire logic        external_zero_delay,
   input wire zd_mode_e    zero_delay_mode,
   input wire logic        status_changed
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   wire logic cw = reg_req.wr && reg_req.addr == 10'h01E;
   wire logic sa = reg_req.addr == 10'h01F;
   chk_rd_pulse: assert property (reg_req.rd |=> rd_valid)
      else $error("no read answer");
   chk_status_read: assert property (reg_req.rd && sa |=>
      rd_data == {1'b0, $past(pll_status)}) else $error("bad status");
   chk_zd_enable: assert property (cw |=>
      zero_delay_enable == $past(reg_req.wdata[1])) else $error("bad enable");
   chk_zd_ext: assert property (cw |=>
      external_zero_delay == &($past(reg_req.wdata[2:1]))) else $error("bad ext");
   chk_cfg_hold: assert property (!cw |=> $stable(zero_delay_enable))
      else $error("enable moved");
   chk_status_wr: assert property (reg_req.wr && sa |=> addr_error)
      else $error("write taken");
   chk_bit_seven: assert property (rd_valid |-> !rd_data[7])
      else $error("bit 7 set");
   chk_rd_hold: assert property (!rd_valid && !$past(srst) |-> $stable(rd_data))
      else $error("rd_data moved");
   cover property (cw);
   cover property (rd_valid && rd_data[6]);
   cover property (addr_error);
   cover property (status_changed);
endmodule // pll_status_asserts
bind pll_status_readback pll_status_asserts i_chk (
   .core_clk            (core_clk),
   .srst                (srst),
   .reg_req             (reg_req),
   .rd_data             (rd_data),
   .rd_valid            (rd_valid),
   .addr_error          (addr_error),
   .pll_status          (pll_status),
   .zero_delay_enable   (zero_delay_enable),
   .external_zero_delay (external_zero_delay),
   .zero_delay_mode     (zero_delay_mode),
   .status_changed      (status_changed)
);
`default_nettype wire

// >>> pll_status_readback_tb.sv
`default_nettype none
module pll_status_readback_tb
   import pll_status_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        core_clk, srst, rd_valid, addr_error, ae;
   logic        zero_delay_enable, external_zero_delay, status_changed;
   logic [7:0]  rd_data;
   reg_req_s    reg_req;
   pll_status_s pll_status;
   zd_mode_e    zero_delay_mode;
   int          n_mismatch = 0;
   int          total_checks = 0;
   pll_status_readback i_dut (
      .core_clk            (core_clk),
      .srst                (srst),
      .reg_req             (reg_req),
      .rd_data             (rd_data),
      .rd_valid            (rd_valid),
      .addr_error          (addr_error),
      .pll_status          (pll_status),
      .zero_delay_enable   (zero_delay_enable),
      .external_zero_delay (external_zero_delay),
      .zero_delay_mode     (zero_delay_mode),
      .status_changed      (status_changed)
   );
   initial
   begin
      core_clk = 0;
      forever #5 core_clk = ~core_clk;
   end
   task chk(input logic [7:0] seen, exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task acc(input reg_addr_t a, input logic w, r, input reg_byte_t d);
      @(negedge core_clk);
      reg_req = '{a, w, r, d};
      @(negedge core_clk);
      reg_req = '0;
      ae = addr_error;
   endtask
   task rd(input reg_addr_t a, input reg_byte_t e);
      acc(a, 1'b0, 1'b1, 8'h00);
      chk(rd_data, e);
      chk({7'h00, rd_valid}, 8'h01);
   endtask
   task t_cfg;
      reg_byte_t v[4];
      v = '{8'h02, 8'h06, 8'h04, 8'hFF};
      foreach (v[i])
      begin
         acc(10'h01E, 1'b1, 1'b0, v[i]);
         chk({7'h00, ae}, 8'h00);
         chk({7'h00, zero_delay_enable}, {7'h00, v[i][1]});
         chk({7'h00, external_zero_delay}, {7'h00, v[i][2] & v[i][1]});
         chk({6'h00, zero_delay_mode}, {6'h00, v[i][2] & v[i][1], v[i][1]});
         rd(10'h01E, v[i] & 8'h06);
      end
      $display("cfg done");
   endtask
   task t_reset;
      @(negedge core_clk);
      srst = 1'b1;
      @(negedge core_clk);
      srst = 1'b0;
      chk({7'h00, zero_delay_enable}, 8'h00);
      rd(10'h01E, 8'h00);
      $display("reset done");
   endtask
   task t_status;
      for (int i = 0; i < 7; i++)
      begin
         pll_status = 7'h01 << i;
         @(negedge core_clk);
         chk({7'h00, status_changed}, 8'h01);
         rd(10'h01F, 8'h01 << i);
         chk({7'h00, status_changed}, 8'h00);
      end
      $display("status done");
   endtask
   task t_ro;
      pll_status = 7'h7F;
      acc(10'h01F, 1'b1, 1'b0, 8'hFF);
      chk({7'h00, ae}, 8'h01);
      rd(10'h01F, 8'h7F);
      rd(10'h01E, 8'h00);
      rd(10'h020, 8'h00);
      chk({7'h00, ae}, 8'h01);
      $display("ro done");
   endtask
   task results;
      $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      #20000;
      n_mismatch++;
      results;
   end
   initial
   begin
      srst = 1;
      reg_req = '0;
      pll_status = '0;
      repeat (10) @(negedge core_clk);
      srst = 0;
      t_cfg;
      t_reset;
      t_status;
      t_ro;
      results;
   end
endmodule // pll_status_readback_tb
`default_nettype wire
